// File: core/smbcr_consts.vh
// constants for the smbus control and status register bank
// Operation
// - init sum fault bit 28, set, write-one clears
// - unmapped init attempt bit 29, set, w1c
// - prescaled clock period is 32 ns times divider
// - divider zero or one stops the clock
// - boot divider 0x0139 slow, 0x0053 fast
// - skip arbitration bit 16 ignores lost arbitration
// - skip sum check bit 17 forces checksum pass
// - slave filter code 0 1 us, 1 100 ns
// - slave filter code 2 zero delay, 3 reserved
// - master filter code 0 1 us, 1 100 ns
// - master filter code 2 disables filtering, 3 reserved
// - timeout off bit 22 disables both timeouts
// - master clock low time is half period
`ifndef SMBCR_CONSTS_VH
`define SMBCR_CONSTS_VH
`define SMBCR_OFF_STATUS   12'h424
`define SMBCR_OFF_CONTROL  12'h428
`define SMBCR_OFF_IRQ_MASK 12'h434
`define SMBCR_ADDR_BITS    12
`define SMBCR_BIT_SUM      28
`define SMBCR_BIT_UNMAP    29
`define SMBCR_DIV_MSB      15
`define SMBCR_BIT_SKIPARB  16
`define SMBCR_BIT_SKIPSUM  17
`define SMBCR_SFILT_LSB    18
`define SMBCR_SFILT_MSB    19
`define SMBCR_MFILT_LSB    20
`define SMBCR_MFILT_MSB    21
`define SMBCR_BIT_TOOFF    22
`define SMBCR_CTL_MASK     32'h007FFFFF
`define SMBCR_DIV_SLOW     16'h0139
`define SMBCR_DIV_FAST     16'h0053
`define SMBCR_BASE_NS      32
`define SMBCR_CLK_NS       100
`define SMBCR_FILT_NORM_NS 1000
`define SMBCR_FILT_FAST_NS 100
`define SMBCR_FILT_NORM    2'h0
`define SMBCR_FILT_FAST    2'h1
`define SMBCR_FILT_OFF     2'h2
`define SMBCR_HTRANS_NSEQ  2'h2
`endif

// File: core/smbcr_glitch.v
// glitch filter: output follows input after it stays stable for a set count
`timescale 1ns/10ps
module smbcr_glitch
#(
  parameter CW = 4
)
(
  // clock and reset
  input  wire          sys_clk_in,
  input  wire          rst_b_in,
  // control
  input  wire [CW-1:0] hold_in,
  input  wire          raw_in,
  // filtered level
  output reg           filt_out
);
  reg [CW-1:0] cnt;

  // count stable cycles, accept level once count reaches hold
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      filt_out <= 1'b1;
      cnt      <= {CW{1'b0}};
    end
    else if (raw_in == filt_out)
      cnt <= {CW{1'b0}};
    else if (cnt >= hold_in)
    begin
      filt_out <= raw_in;
      cnt      <= {CW{1'b0}};
    end
    else
      cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
  end
endmodule

// File: core/smbcr_regs.v
// smbus control and upper status register bank with ahb-lite slave
`timescale 1ns/10ps
`include "smbcr_consts.vh"
module smbcr_regs
#(
  parameter FW = 4
)
(
  // clock and reset
  input  wire        sys_clk_in,
  input  wire        rst_b_in,
  // ahb-lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output reg         hreadyout_out,
  output reg         hresp_out,
  // boot strap and init events
  input  wire        boot_fast_in,
  input  wire        init_sum_bad_in,
  input  wire        init_no_done_in,
  input  wire        init_unmapped_in,
  // arbitration and timeouts from bus engines
  input  wire        master_arb_lost_in,
  input  wire        master_timeout_in,
  input  wire        slave_timeout_in,
  // raw bus lines
  input  wire        slave_bus_clock_in,
  input  wire        slave_bus_data_in,
  input  wire        master_bus_clock_in,
  input  wire        master_bus_data_in,
  // filtered lines
  output reg         slave_bus_clock_out,
  output reg         slave_bus_data_out,
  output reg         master_bus_clock_out,
  output reg         master_bus_data_out,
  // engine controls
  output reg         master_prescale_tick_out,
  output reg         master_abort_out,
  output reg         master_timeout_out,
  output reg         slave_timeout_out,
  // interrupt
  output reg         irq_out
);
  localparam ST_BOOT = 2'b01;
  localparam ST_RUN  = 2'b10;
  // hold counts in clock cycles, sliced to the filter counter width
  localparam integer HOLD_NORM_I = `SMBCR_FILT_NORM_NS / `SMBCR_CLK_NS;
  localparam integer HOLD_FAST_I = `SMBCR_FILT_FAST_NS / `SMBCR_CLK_NS;
  localparam [FW-1:0] HOLD_NORM = HOLD_NORM_I[FW-1:0];
  localparam [FW-1:0] HOLD_FAST = (HOLD_FAST_I == 0) ? {{(FW-1){1'b0}}, 1'b1}
                                                     : HOLD_FAST_I[FW-1:0];
  // positions in the synchronised event vector
  localparam EV_SUM    = 0;
  localparam EV_NODONE = 1;
  localparam EV_UNMAP  = 2;
  localparam EV_MTO    = 3;
  localparam EV_STO    = 4;
  localparam EV_ARB    = 5;
  localparam EV_W      = 6;

  reg [1:0]  state;
  reg [31:0] ctl;
  reg        sum_fault;
  reg        unmap_fault;
  reg [1:0]  irq_mask;
  reg        wr_pend;
  reg [`SMBCR_ADDR_BITS-1:0] wr_addr;
  reg [31:0] div_cnt;
  reg [31:0] div_lim;
  reg [31:0] next_div_cnt;
  reg        next_tick;
  reg [3:0]  s_sync1;
  reg [3:0]  s_sync2;
  reg [EV_W-1:0] ev_sync1;
  reg [EV_W-1:0] ev_sync2;
  reg        boot_sync1;
  reg        boot_sync2;
  wire [3:0] filt;
  wire       addr_ph;
  wire       w_ctl;
  wire       w_sts;
  wire       w_msk;
  wire       set_sum;
  wire       set_unmap;
  wire [FW-1:0] s_hold;
  wire [FW-1:0] m_hold;
  wire       div_stop;

  // filter code to hold count
  function [FW-1:0] smbcr_hold;
    input [1:0] code;
    begin
      case (code)
        `SMBCR_FILT_NORM: smbcr_hold = HOLD_NORM;
        `SMBCR_FILT_FAST: smbcr_hold = HOLD_FAST;
        default:          smbcr_hold = {FW{1'b0}};
      endcase
    end
  endfunction

  // register read mux
  function [31:0] smbcr_read;
    input [`SMBCR_ADDR_BITS-1:0] a;
    input [31:0] c;
    input        s;
    input        u;
    input [1:0]  m;
    begin
      case (a)
        `SMBCR_OFF_CONTROL:  smbcr_read = c & `SMBCR_CTL_MASK;
        `SMBCR_OFF_STATUS:   smbcr_read = {2'h0, u, s, 28'h0000000};
        `SMBCR_OFF_IRQ_MASK: smbcr_read = {2'h0, m, 28'h0000000};
        default:             smbcr_read = 32'h00000000;
      endcase
    end
  endfunction

  assign addr_ph = hsel_in & hready_in & (htrans_in == `SMBCR_HTRANS_NSEQ);
  assign w_ctl = wr_pend & (wr_addr == `SMBCR_OFF_CONTROL);
  assign w_sts = wr_pend & (wr_addr == `SMBCR_OFF_STATUS);
  assign w_msk = wr_pend & (wr_addr == `SMBCR_OFF_IRQ_MASK);
  // checksum failure counts only when not overridden
  assign set_sum = (ev_sync2[EV_SUM] & ~ctl[`SMBCR_BIT_SKIPSUM]) | ev_sync2[EV_NODONE];
  assign set_unmap = ev_sync2[EV_UNMAP];
  assign s_hold = smbcr_hold(ctl[`SMBCR_SFILT_MSB:`SMBCR_SFILT_LSB]);
  assign m_hold = smbcr_hold(ctl[`SMBCR_MFILT_MSB:`SMBCR_MFILT_LSB]);
  // divider of zero or one holds the prescaler stopped
  assign div_stop = (ctl[`SMBCR_DIV_MSB:1] == 15'h0000);

  // pin and event synchronisers
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      s_sync1    <= 4'hF;
      s_sync2    <= 4'hF;
      ev_sync1   <= {EV_W{1'b0}};
      ev_sync2   <= {EV_W{1'b0}};
    end
    else
    begin
      s_sync1    <= {master_bus_data_in, master_bus_clock_in,
                     slave_bus_data_in, slave_bus_clock_in};
      s_sync2    <= s_sync1;
      ev_sync1   <= {master_arb_lost_in, slave_timeout_in, master_timeout_in,
                     init_unmapped_in, init_no_done_in, init_sum_bad_in};
      ev_sync2   <= ev_sync1;
    end
  end

  // strap synchroniser runs through reset, so the boot load
  // already sees the settled strap level on the first cycle after release
  always @(posedge sys_clk_in)
  begin
    boot_sync1 <= boot_fast_in;
    boot_sync2 <= boot_sync1;
  end

  // glitch filters, one per line
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_filt
      smbcr_glitch #(.CW(FW)) u_filt
      (
        .sys_clk_in (sys_clk_in),
        .rst_b_in   (rst_b_in),
        .hold_in    ((gi < 2) ? s_hold : m_hold),
        .raw_in     (s_sync2[gi]),
        .filt_out   (filt[gi])
      );
    end
  endgenerate

  // filtered lines to flops
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      slave_bus_clock_out  <= 1'b1;
      slave_bus_data_out   <= 1'b1;
      master_bus_clock_out <= 1'b1;
      master_bus_data_out  <= 1'b1;
    end
    else
    begin
      slave_bus_clock_out  <= filt[0];
      slave_bus_data_out   <= filt[1];
      master_bus_clock_out <= filt[2];
      master_bus_data_out  <= filt[3];
    end
  end

  // ahb-lite slave, zero wait state
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      wr_pend       <= 1'b0;
      wr_addr       <= {`SMBCR_ADDR_BITS{1'b0}};
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
      hrdata_out    <= 32'h00000000;
    end
    else
    begin
      wr_pend <= addr_ph & hwrite_in;
      if (addr_ph)
        wr_addr <= haddr_in[`SMBCR_ADDR_BITS-1:0];
      if (addr_ph & ~hwrite_in)
        hrdata_out <= smbcr_read(haddr_in[`SMBCR_ADDR_BITS-1:0], ctl,
                                 sum_fault, unmap_fault, irq_mask);
    end
  end

  // control register, boot load then software writes
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      state <= ST_BOOT;
      ctl   <= 32'h00000000;
    end
    else
    begin
      case (state)
        ST_BOOT:
        begin
          ctl[`SMBCR_DIV_MSB:0] <= boot_sync2 ? `SMBCR_DIV_FAST : `SMBCR_DIV_SLOW;
          state <= ST_RUN;
        end
        ST_RUN:
          if (w_ctl)
            ctl <= hwdata_in & `SMBCR_CTL_MASK;
        default:
          state <= ST_BOOT;
      endcase
    end
  end

  // sticky init faults and mask, set beats clear
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      sum_fault   <= 1'b0;
      unmap_fault <= 1'b0;
      irq_mask    <= 2'h0;
    end
    else
    begin
      if (set_sum)
        sum_fault <= 1'b1;
      else if (w_sts & hwdata_in[`SMBCR_BIT_SUM])
        sum_fault <= 1'b0;
      if (set_unmap)
        unmap_fault <= 1'b1;
      else if (w_sts & hwdata_in[`SMBCR_BIT_UNMAP])
        unmap_fault <= 1'b0;
      if (w_msk)
        irq_mask <= hwdata_in[`SMBCR_BIT_UNMAP:`SMBCR_BIT_SUM];
    end
  end

  // prescaler next state: the tick toggles every half period,
  // so the low phase of the master clock is half the period
  always @*
  begin
    next_div_cnt = div_cnt;
    next_tick    = master_prescale_tick_out;
    if (div_stop)
    begin
      next_div_cnt = 32'h00000000;
      next_tick    = 1'b0;
    end
    else if (div_cnt + 32'h00000001 >= div_lim)
    begin
      next_div_cnt = 32'h00000000;
      next_tick    = ~master_prescale_tick_out;
    end
    else
      next_div_cnt = div_cnt + 32'h00000001;
  end

  // prescaler flops; the half-period limit is registered so the divide
  // stays off the counter path, it lags a divider write by one cycle
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      div_lim                  <= 32'h00000000;
      div_cnt                  <= 32'h00000000;
      master_prescale_tick_out <= 1'b0;
    end
    else
    begin
      div_lim                  <= (ctl[`SMBCR_DIV_MSB:0] * `SMBCR_BASE_NS)
                                  / (2 * `SMBCR_CLK_NS);
      div_cnt                  <= next_div_cnt;
      master_prescale_tick_out <= next_tick;
    end
  end

  // lost arbitration aborts unless other masters are ignored
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      master_abort_out <= 1'b0;
    else
      master_abort_out <= ev_sync2[EV_ARB] & ~ctl[`SMBCR_BIT_SKIPARB];
  end

  // timeout requests reach the engines only while timeouts are on
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      master_timeout_out <= 1'b0;
      slave_timeout_out  <= 1'b0;
    end
    else
    begin
      master_timeout_out <= ev_sync2[EV_MTO] & ~ctl[`SMBCR_BIT_TOOFF];
      slave_timeout_out  <= ev_sync2[EV_STO] & ~ctl[`SMBCR_BIT_TOOFF];
    end
  end

  // level interrupt while an unmasked sticky fault is set
  always @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
      irq_out <= 1'b0;
    else
      irq_out <= (sum_fault & irq_mask[0]) | (unmap_fault & irq_mask[1]);
  end
endmodule

// File: test/smbcr_properties.sv
// port checker for the smbus register bank
`timescale 1ns/10ps
module smbcr_props
(
  // watched ports
  input wire        sys_clk_in,
  input wire        rst_b_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire        hready_in,
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire        master_timeout_in,
  input wire        slave_timeout_in,
  input wire        master_timeout_out,
  input wire        slave_timeout_out,
  input wire        irq_out
);
  reg [2:0] m_age;
  reg [2:0] s_age;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // cycles since each timeout request, saturating
  always @(posedge sys_clk_in)
  begin
    m_age <= (master_timeout_in || !rst_b_in) ? 3'h0 : m_age + {2'h0, m_age != 3'h7};
    s_age <= (slave_timeout_in || !rst_b_in) ? 3'h0 : s_age + {2'h0, s_age != 3'h7};
  end
  // read address phase
  sequence s_rd(a);
    hsel_in && hready_in && htrans_in == 2'h2 && !hwrite_in && haddr_in[11:0] == a;
  endsequence
  property p_rd_zero(a, m);
    s_rd(a) |=> (hrdata_out & m) == 32'h0;
  endproperty
  a_resp_okay: assert property (!hresp_out && hreadyout_out) else $error("bad response");
  a_status_rsvd: assert property (p_rd_zero(12'h424, 32'hCFFFFFFF)) else $error("status");
  a_ctl_rsvd: assert property (p_rd_zero(12'h428, 32'hFF800000)) else $error("control");
  a_mask_rsvd: assert property (p_rd_zero(12'h434, 32'hCFFFFFFF)) else $error("mask");
  a_unmap_zero: assert property (s_rd(12'h500) |=> hrdata_out == 32'h0) else $error("unmap");
  a_mto_cause: assert property (master_timeout_out |-> m_age < 3'h5) else $error("mto");
  a_sto_cause: assert property (slave_timeout_out |-> s_age < 3'h5) else $error("sto");
  a_reset_idle: assert property (disable iff (1'b0) !rst_b_in |=> !irq_out && !hrdata_out[0]
    && !master_timeout_out) else $error("reset");
endmodule
bind smbcr_regs smbcr_props u_props (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .master_timeout_in(master_timeout_in), .irq_out(irq_out),
  .slave_timeout_in(slave_timeout_in), .master_timeout_out(master_timeout_out),
  .slave_timeout_out(slave_timeout_out));

// File: test/smbcr_partner.sv
// far-side smbus devices: open-drain lines with pull-ups
`timescale 1ns/10ps
module smbcr_partner
(
  // clock and pull request
  input  wire       sys_clk_in,
  input  wire [3:0] pull_in,
  input  wire [3:0] len_in,
  // line levels
  output reg  [3:0] line_out
);
  reg [3:0] left = 4'h0;
  initial line_out = 4'hF;
  // hold lines low for a count, pull-up restores high
  always @(posedge sys_clk_in)
  begin
    if (pull_in != 4'h0)
    begin
      left <= len_in;
      line_out <= ~pull_in;
    end
    else if (left > 4'h1)
      left <= left - 4'h1;
    else
      line_out <= 4'hF;
  end
endmodule

// File: test/smbus_control_status_regs_test.sv
// self-checking bench for the smbus register bank
`timescale 1ns/10ps
module smbus_control_status_regs_test;
  reg         sys_clk_in = 0;
  reg         rst_b_in = 0;
  reg         hs = 0, hw = 0, fast = 0;
  reg  [1:0]  ht = 0;
  reg  [31:0] ha = 0, hwd = 0, q;
  reg  [2:0]  ev = 0, eng = 0;
  reg  [3:0]  pull = 0, lo;
  wire [3:0]  line, fout;
  wire [31:0] hrd;
  wire        rdy, resp, tick, mto, sto, irq, abort;
  integer     miscompares = 0, cmp_count = 0, i, n, k;
  always #50 sys_clk_in = ~sys_clk_in;
  // design and far-side devices
  smbcr_regs dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .hsel_in(hs), .haddr_in(ha),
    .htrans_in(ht), .hwrite_in(hw), .hsize_in(3'h2), .hwdata_in(hwd), .hready_in(rdy),
    .hrdata_out(hrd), .hreadyout_out(rdy), .hresp_out(resp), .boot_fast_in(fast),
    .init_sum_bad_in(ev[0]), .init_no_done_in(ev[1]), .init_unmapped_in(ev[2]),
    .master_arb_lost_in(eng[0]), .master_timeout_in(eng[1]), .slave_timeout_in(eng[2]),
    .slave_bus_clock_in(line[0]), .slave_bus_data_in(line[1]), .master_bus_clock_in(line[2]),
    .master_bus_data_in(line[3]), .slave_bus_clock_out(fout[0]), .slave_bus_data_out(fout[1]),
    .master_bus_clock_out(fout[2]), .master_bus_data_out(fout[3]),
    .master_prescale_tick_out(tick), .master_abort_out(abort), .master_timeout_out(mto),
    .slave_timeout_out(sto), .irq_out(irq));
  smbcr_partner bus (.sys_clk_in(sys_clk_in), .pull_in(pull), .len_in(4'h5), .line_out(line));
  task end_of_test;
  begin
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
  begin
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  // wait for hready, bounded
  task wt;
  begin
    i = 0;
    do begin @(posedge sys_clk_in); i++; end while (rdy !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      miscompares++;
      end_of_test;
    end
  end
  endtask
  task xfer(input w, input [11:0] a, input [31:0] d);
  begin
    hs <= 1'b1; ht <= 2'h2; hw <= w; ha <= {20'h0, a};
    wt;
    hs <= 1'b0; ht <= 2'h0; hwd <= d;
    wt;
    q = hrd;
  end
  endtask
  task rd(input [11:0] a, input [31:0] e, input string nm);
  begin
    xfer(1'b0, a, 32'h0);
    chk(nm, e, q);
  end
  endtask
  task wr(input [11:0] a, input [31:0] d);
  begin
    xfer(1'b1, a, d);
    cyc(1);
  end
  endtask
  task pulse_ev(input integer b);
  begin
    ev[b] <= 1'b1;
    cyc(3);
    ev <= 3'h0;
    cyc(6);
  end
  endtask
  task tog;
  begin
    q[0] = tick;
    i = 0;
    do begin @(posedge sys_clk_in); i++; end while (tick === q[0] && i < 200);
    if (i >= 200)
    begin
      miscompares++;
      end_of_test;
    end
  end
  endtask
  // main sequence
  initial
  begin
    cyc(5); rst_b_in <= 1'b1; cyc(2);
    rd(12'h428, 32'h00000139, "div slow");
    rd(12'h424, 32'h0, "status");
    rd(12'h434, 32'h0, "mask");
    rd(12'h500, 32'h0, "unmapped read");
    wr(12'h428, 32'hFFFFFFFF); rd(12'h428, 32'h007FFFFF, "control rw");
    fast <= 1'b1; rst_b_in <= 1'b0; cyc(5); rst_b_in <= 1'b1; cyc(2);
    rd(12'h428, 32'h00000053, "div fast");
    $display("reset test done");
    wr(12'h434, 32'h30000000); pulse_ev(0); rd(12'h424, 32'h10000000, "sum fault");
    chk("irq", 1, irq);
    wr(12'h424, 32'h0); rd(12'h424, 32'h10000000, "w1c zero");
    wr(12'h424, 32'h10000000); rd(12'h424, 32'h0, "w1c one");
    pulse_ev(2); rd(12'h424, 32'h20000000, "unmapped init");
    wr(12'h434, 32'h0); cyc(2); chk("irq masked", 0, irq);
    wr(12'h424, 32'h20000000); wr(12'h428, 32'h00020000);
    pulse_ev(0); rd(12'h424, 32'h0, "skip sum");
    pulse_ev(1); rd(12'h424, 32'h10000000, "no done");
    $display("event test done");
    for (k = 0; k < 2; k++)
    begin
      wr(12'h428, k ? 32'h00410000 : 32'h0);
      eng <= 3'h7; cyc(6);
      chk("master timeout", k == 0, mto);
      chk("slave timeout", k == 0, sto);
      chk("arbitration abort", k == 0, abort);
      eng <= 3'h0; cyc(6);
    end
    for (k = 0; k < 3; k++)
    begin
      wr(12'h428, (k << 18) | (k << 20));
      pull <= 4'hF; cyc(1); pull <= 4'h0; lo = 4'hF;
      repeat (25) begin @(posedge sys_clk_in); lo = lo & fout; end
      chk("filter", k == 0 ? 4'hF : 4'h0, lo);
    end
    $display("timeout and filter tests done");
    wr(12'h428, 32'd25); tog; tog; chk("half period", 25 * 32 / 200, i);
    for (k = 0; k < 2; k++)
    begin
      wr(12'h428, k); n = 0;
      repeat (60) begin @(posedge sys_clk_in); if (tick !== 1'b0) n++; end
      chk("clock stopped", 0, n);
    end
    $display("prescaler test done");
    end_of_test;
  end
endmodule
